/* rtl/pgit_consts.svh */
// Timing constants for the power gating interval timer.
// Assumes a single core clock at 40 MHz; counts derive from it, except the interval maximum, which uses a fixed 40000 cycles per ms.
`ifndef PGIT_CONSTS_SVH
`define PGIT_CONSTS_SVH

`define PGIT_CLK_HZ 40000000
// Guard window at end of every interval, in ms
`define PGIT_GUARD_MS 50
`define PGIT_GUARD_CYC ((`PGIT_CLK_HZ / 1000) * `PGIT_GUARD_MS)
// Manual-on filter: minimum width and observation window, in ms
`define PGIT_MAN_MIN_MS 20
`define PGIT_MAN_MIN_CYC ((`PGIT_CLK_HZ / 1000) * `PGIT_MAN_MIN_MS)
`define PGIT_MAN_OBS_MS 30
`define PGIT_MAN_OBS_CYC ((`PGIT_CLK_HZ / 1000) * `PGIT_MAN_OBS_MS)
// Resistor conversion time, in ms
`define PGIT_MEAS_MS 100
`define PGIT_MEAS_CYC ((`PGIT_CLK_HZ / 1000) * `PGIT_MEAS_MS)
// Interval range, in ms
`define PGIT_IVL_MIN_MS 100
`define PGIT_IVL_MAX_MS 7200000
`define PGIT_IVL_MIN_CYC ((`PGIT_CLK_HZ / 1000) * `PGIT_IVL_MIN_MS)
`define PGIT_IVL_MAX_CYC (64'd40000 * 64'd7200000)

`endif

/* rtl/pgit_pkg.sv */
// Types shared by the power gating interval timer.
// Assumes the constants header is included by the design file.
`default_nettype none
package pgit_pkg;
   // Top-level sequencer states
   typedef enum logic [1:0] {
      PGIT_MEASURE,
      PGIT_IDLE,
      PGIT_DRIVE,
      PGIT_GUARD
   } pgit_state_t;

   // Result of the one-time resistor measurement
   typedef struct packed {
      logic valid;
      logic [38:0] cycles;
   } pgit_interval_t;
endpackage
`default_nettype wire

/* rtl/pgit_timer.sv */
// Power gating interval timer: drives an active-low MOSFET gate.
// Assumes one 40 MHz clock, sync reset standing for power-on reset, and
// an external converter that reports the resistor reading as a cycle count.
`include "pgit_consts.svh"
`default_nettype none

// ----------------------------------------------------------------
// Design notes
// ----------------------------------------------------------------
// Time base
//    Every count runs on core_clk; no prescaler.
//    Wide counters trade area for one clock domain.
//    Interval counter is 39 bits to reach the longest interval.
//    Filter counters are 32 bits; ample for millisecond windows.
//
// Measurement phase
//    The analog conversion sits outside this block.
//    Its result arrives as a cycle count, sampled once.
//    A held manual level restarts the conversion count,
//    so a stuck switch delays start-up rather than
//    fixing a bogus interval.
//    The mode pin is sampled at the same edge; later
//    changes on it are not looked at.
//
// Gate sequencing
//    Interval start: gate falls and the counter clears.
//    Drive phase ends at interval minus guard, or on
//    the first accepted acknowledge.
//    Guard phase holds the gate high until the interval
//    ends or a manual request is accepted, so the switch
//    opens before the next start.
//    An early acknowledge stretches the high time, not
//    the interval: the counter keeps running.
//
// Acknowledge handling
//    Only a rising edge counts; a long high level acts once.
//    One acknowledge per interval; later ones are dropped.
//    Acknowledges in the guard phase still use up the
//    interval's single acknowledge.
//    While the manual level is high nothing is accepted,
//    so a held switch keeps the host powered.
//
// Manual power-on
//    The level must be high for the minimum width in total inside
//    the observation window before it counts.
//    After a valid request the filter waits for a full
//    filter time low, so release bounce is harmless.
//    A request while the gate is low is dropped.
//    While the validated request is still held the interval
//    counter stays at zero; counting starts on release.
//    A second press during that pulse is not a new request
//    and does not stop the count again.
//
// Limitations
//    Pin electrical behaviour is not modelled here.
//    The resistor-to-interval arithmetic is done outside.
//    Gate output comes straight from a flip-flop; the pad
//    decides the edge rates.
//    Input lag is four clocks at most through the
//    synchronisers, small against millisecond windows.
//
// Reset
//    Reset stands for power-on reset: all timing clears,
//    the gate rests high and measurement starts over.
//

module pgit_timer #(
   parameter int unsigned GUARD_CYC = `PGIT_GUARD_CYC,
   parameter int unsigned MAN_MIN_CYC = `PGIT_MAN_MIN_CYC,
   parameter int unsigned MAN_OBS_CYC = `PGIT_MAN_OBS_CYC,
   parameter int unsigned MEAS_CYC = `PGIT_MEAS_CYC,
   parameter logic [38:0] IVL_MIN_CYC = 39'(`PGIT_IVL_MIN_CYC),
   parameter logic [38:0] IVL_MAX_CYC = 39'(`PGIT_IVL_MAX_CYC)
) (
   input wire logic core_clk,
   input wire logic reset,
   // Shared pin, digital view: high means manual power-on request
   input wire logic interval_set_manual_on,
   // Resistor reading in clock cycles, sampled when measurement ends
   input wire pgit_pkg::pgit_interval_t interval_resistor,
   input wire logic done,
   input wire logic mode_periodic,
   output logic gate_drive_n,
   output logic measuring
);

   // ----------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------
   logic [2:0] man_sync_q;
   logic [2:0] done_sync_q;
   logic [2:0] mode_sync_q;
   logic man_lvl_q;
   logic done_lvl_q;
   logic mode_lvl_q;

   // Three stages; a change counts once stages two and three agree
   always_ff @(posedge core_clk) begin
      if (reset) begin
         man_sync_q <= 3'h0;
         done_sync_q <= 3'h0;
         mode_sync_q <= 3'h0;
         man_lvl_q <= 1'b0;
         done_lvl_q <= 1'b0;
         mode_lvl_q <= 1'b0;
      end else begin
         man_sync_q <= {man_sync_q[1:0], interval_set_manual_on};
         done_sync_q <= {done_sync_q[1:0], done};
         mode_sync_q <= {mode_sync_q[1:0], mode_periodic};
         if (man_sync_q[1] == man_sync_q[2])
            man_lvl_q <= man_sync_q[2];
         if (done_sync_q[1] == done_sync_q[2])
            done_lvl_q <= done_sync_q[2];
         if (mode_sync_q[1] == mode_sync_q[2])
            mode_lvl_q <= mode_sync_q[2];
      end
   end

   // Rising edge only; falling edges mean nothing
   wire done_rise = done_sync_q[2] & ~done_lvl_q;

   // ----------------------------------------------------------------
   // Manual power-on filter
   // ----------------------------------------------------------------
   logic [31:0] obs_cnt_q;
   logic [31:0] high_cnt_q;
   logic man_valid_q;
   logic man_held_q;

   // Window opens on a high level; request valid once high for the
   // minimum width inside the window. Released only after a full
   // filter time low, so bounce on release does not retrigger.
   wire obs_open = (obs_cnt_q != 32'h0);
   wire man_hit = man_lvl_q && (high_cnt_q + 32'h1 >= MAN_MIN_CYC);
   always_ff @(posedge core_clk) begin
      if (reset) begin
         obs_cnt_q <= 32'h0;
         high_cnt_q <= 32'h0;
         man_valid_q <= 1'b0;
         man_held_q <= 1'b0;
      end else if (man_held_q) begin
         // Hold until input low for the debounce time
         if (man_lvl_q)
            high_cnt_q <= 32'h0;
         else
            high_cnt_q <= high_cnt_q + 32'h1;
         man_valid_q <= 1'b0;
         if (!man_lvl_q && high_cnt_q + 32'h1 >= MAN_MIN_CYC)
            man_held_q <= 1'b0;
      end else if (man_hit && obs_open) begin
         man_valid_q <= 1'b1;
         man_held_q <= 1'b1;
         obs_cnt_q <= 32'h0;
         high_cnt_q <= 32'h0;
      end else if (obs_open) begin
         obs_cnt_q <= (obs_cnt_q + 32'h1 >= MAN_OBS_CYC) ?
            32'h0 : obs_cnt_q + 32'h1;
         high_cnt_q <= man_lvl_q ? high_cnt_q + 32'h1 : high_cnt_q;
         man_valid_q <= 1'b0;
      end else begin
         obs_cnt_q <= man_lvl_q ? 32'h1 : 32'h0;
         high_cnt_q <= man_lvl_q ? 32'h1 : 32'h0;
         man_valid_q <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Interval sequencer
   // ----------------------------------------------------------------
   pgit_pkg::pgit_state_t state_q;
   logic [38:0] ivl_q;
   logic [38:0] cnt_q;
   logic [31:0] meas_q;
   logic periodic_q;
   logic acked_q;
   logic manual_run_q;
   logic gate_q;

   // Clamp the reading into the selectable range
   wire [38:0] rd = interval_resistor.cycles;
   wire [38:0] ivl_clamped = (rd < IVL_MIN_CYC) ? IVL_MIN_CYC :
      (rd > IVL_MAX_CYC) ? IVL_MAX_CYC : rd;
   wire [38:0] drive_end = ivl_q - 39'(GUARD_CYC);
   wire cnt_last = (cnt_q + 39'h1 >= ivl_q);
   wire drive_last = (cnt_q + 39'h1 >= drive_end);
   // Acknowledge held off while manual input high or already used
   wire ack_ok = done_rise && !acked_q && !man_lvl_q;
   // Manual request only counts while gate high
   wire man_go = man_valid_q && gate_q;

   always_ff @(posedge core_clk) begin
      if (reset) begin
         state_q <= pgit_pkg::PGIT_MEASURE;
         ivl_q <= 39'h0;
         cnt_q <= 39'h0;
         meas_q <= 32'h0;
         periodic_q <= 1'b0;
         acked_q <= 1'b0;
         manual_run_q <= 1'b0;
         gate_q <= 1'b1;
      end else begin
         unique case (state_q)
            pgit_pkg::PGIT_MEASURE: begin
               // Manual-on aborts and restarts the measurement
               if (man_lvl_q)
                  meas_q <= 32'h0;
               else if (meas_q + 32'h1 >= MEAS_CYC) begin
                  ivl_q <= ivl_clamped;
                  periodic_q <= mode_lvl_q;
                  cnt_q <= 39'h0;
                  acked_q <= 1'b0;
                  gate_q <= 1'b0;
                  state_q <= pgit_pkg::PGIT_DRIVE;
               end else
                  meas_q <= meas_q + 32'h1;
            end
            pgit_pkg::PGIT_DRIVE: begin
               // Hold ends at release; a later press is ignored
               if (!man_lvl_q)
                  manual_run_q <= 1'b0;
               if (man_lvl_q && manual_run_q)
                  cnt_q <= 39'h0; // counting resumes on release
               else
                  cnt_q <= cnt_q + 39'h1;
               if (man_lvl_q && manual_run_q) begin
                  gate_q <= 1'b0; // long hold keeps host on
               end else if (ack_ok) begin
                  acked_q <= 1'b1;
                  gate_q <= 1'b1;
                  state_q <= pgit_pkg::PGIT_GUARD;
               end else if (drive_last) begin
                  gate_q <= 1'b1;
                  state_q <= pgit_pkg::PGIT_GUARD;
               end
            end
            pgit_pkg::PGIT_GUARD: begin
               cnt_q <= cnt_q + 39'h1;
               if (done_rise)
                  acked_q <= 1'b1;
               if (man_go) begin
                  cnt_q <= 39'h0;
                  acked_q <= 1'b0;
                  manual_run_q <= 1'b1;
                  gate_q <= 1'b0;
                  state_q <= pgit_pkg::PGIT_DRIVE;
               end else if (cnt_last && periodic_q) begin
                  cnt_q <= 39'h0;
                  acked_q <= 1'b0;
                  manual_run_q <= 1'b0;
                  gate_q <= 1'b0;
                  state_q <= pgit_pkg::PGIT_DRIVE;
               end else if (cnt_last) begin
                  manual_run_q <= 1'b0;
                  state_q <= pgit_pkg::PGIT_IDLE;
               end
            end
            pgit_pkg::PGIT_IDLE: begin
               // One-shot rest; gate stays high
               if (man_go) begin
                  cnt_q <= 39'h0;
                  acked_q <= 1'b0;
                  manual_run_q <= 1'b1;
                  gate_q <= 1'b0;
                  state_q <= pgit_pkg::PGIT_DRIVE;
               end
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   // Low powers the host; high from reset through measurement
   assign gate_drive_n = gate_q;
   assign measuring = (state_q == pgit_pkg::PGIT_MEASURE);

endmodule
`default_nettype wire

/* dv/pgit_timer_props.sv */
// Port checker for the interval timer.
// Assumes the bench shortens the guard window to 5 cycles.
`default_nettype none
// ----
// Checker
// ----
module pgit_timer_props #(
   parameter int unsigned GUARD_CYC = 5
) (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic interval_set_manual_on,
   input wire pgit_pkg::pgit_interval_t interval_resistor,
   input wire logic done,
   input wire logic mode_periodic,
   input wire logic gate_drive_n,
   input wire logic measuring
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (reset);
   logic [3:0] man_h_q;
   logic [38:0] low_q;
   wire man_recent = interval_set_manual_on | (|man_h_q);
   // Low-time count; input lag makes it start late, never early
   always_ff @(posedge core_clk) begin
      man_h_q <= {man_h_q[2:0], interval_set_manual_on};
      low_q <= (gate_drive_n || man_recent) ? 39'h0 : low_q + 39'h1;
   end
   property p_rst;
      disable iff (1'b0) reset |=> gate_drive_n && measuring;
   endproperty
   property p_meas;
      measuring |-> gate_drive_n;
   endproperty
   property p_start;
      $fell(measuring) |-> !gate_drive_n;
   endproperty
   property p_width;
      !gate_drive_n |-> low_q < interval_resistor.cycles - 39'(GUARD_CYC);
   endproperty
   property p_guard;
      $rose(gate_drive_n) |-> gate_drive_n[*5];
   endproperty
   property p_ack;
      $rose(done) && !gate_drive_n && !man_recent |-> ##[1:6] gate_drive_n;
   endproperty
   property p_manual;
      interval_set_manual_on[*8] ##0 (gate_drive_n && !measuring)
         |-> ##[0:8] !gate_drive_n;
   endproperty
   property p_glitch;
      !interval_set_manual_on[*6] ##1 interval_set_manual_on[*2] ##1
         (!interval_set_manual_on && !mode_periodic && gate_drive_n
         && !measuring) |=> gate_drive_n[*8];
   endproperty
   property p_once;
      !measuring |=> !measuring;
   endproperty
   a_rst: assert property (p_rst) else $error("gate not off in reset");
   a_meas: assert property (p_meas) else $error("gate on while measuring");
   a_start: assert property (p_start) else $error("no pulse at start");
   a_width: assert property (p_width) else $error("pulse too long");
   a_guard: assert property (p_guard) else $error("guard window cut");
   a_ack: assert property (p_ack) else $error("ack not obeyed");
   a_manual: assert property (p_manual) else $error("manual too slow");
   a_glitch: assert property (p_glitch) else $error("glitch acted on");
   a_once: assert property (p_once) else $error("measured again");
   c_ack: cover property ($rose(done) && !gate_drive_n);
   c_man: cover property (interval_set_manual_on[*8]);
   c_shot: cover property (!mode_periodic && $fell(gate_drive_n));
endmodule
`default_nettype wire

/* dv/pgit_host_model.sv */
// Host model: acknowledges each gate pulse on done.
// Assumes gate_drive_n moves just after rising clock edges.
`default_nettype none
module pgit_host_model (
   input wire logic core_clk,
   input wire logic gate_drive_n,
   input wire logic [7:0] ack_dly,
   input wire logic ack_twice,
   output logic done
);
   timeunit 1ns;
   timeprecision 100ps;
   // Delay of 5 or less means a silent host; pulled down when idle
   // Ack at least 150 ns after the fall
   // Held 6 cycles, 150 ns, above the minimum width
   initial begin
      done = 1'b0;
      forever begin
         @(negedge gate_drive_n);
         if (ack_dly > 8'h05) begin
            repeat (ack_dly) @(posedge core_clk);
            done <= 1'b1;
            repeat (6) @(posedge core_clk);
            done <= 1'b0;
            if (ack_twice) begin
               repeat (3) @(posedge core_clk);
               done <= 1'b1;
               repeat (6) @(posedge core_clk);
               done <= 1'b0;
            end
         end
      end
   end
endmodule
`default_nettype wire

/* dv/pgit_timer_tb_top.sv */
// Testbench for the interval timer, with short counts.
// Assumes guard 5, manual 4 of 6, measure 10, interval 40.
`default_nettype none
module pgit_timer_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int IVL = 40;
   localparam int GUARD = 5;
   logic core_clk, reset, man, done, mode, twice, gate_drive_n, measuring;
   logic [7:0] ack_dly;
   pgit_pkg::pgit_interval_t ivl_in;
   int err_total, n_compared, n, k;
   pgit_timer #(.GUARD_CYC(GUARD), .MAN_MIN_CYC(4), .MAN_OBS_CYC(6),
      .MEAS_CYC(10), .IVL_MIN_CYC(39'h14)) pgit_timer_inst (
      .core_clk(core_clk), .reset(reset), .interval_set_manual_on(man),
      .interval_resistor(ivl_in), .done(done), .mode_periodic(mode),
      .gate_drive_n(gate_drive_n), .measuring(measuring));
   pgit_host_model pgit_host_model_inst (.core_clk(core_clk),
      .gate_drive_n(gate_drive_n), .ack_dly(ack_dly), .ack_twice(twice),
      .done(done));
   // ----
   // Helpers
   // ----
   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   task automatic chk_bit(input logic got, input logic exp, input string m);
      n_compared++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value at %0t: %s", $time, m);
      end
   endtask
   task automatic chk_cnt(input int got, input int lo, input int hi,
                          input string m);
      n_compared++;
      if (got < lo || got > hi) begin
         err_total++;
         $display("wrong value at %0t: %s %0d", $time, m, got);
      end
   endtask
   // Bounded wait; n holds the cycles spent
   task automatic wait_gate(input logic v, input int lim);
      n = 0;
      while (gate_drive_n !== v && n < lim) begin
         @(posedge core_clk);
         #1;
         n++;
      end
   endtask
   task automatic restart(input logic m, input logic [7:0] a);
      @(posedge core_clk);
      reset <= 1'b1;
      mode <= m; // fixed for the whole run
      ack_dly <= a;
      repeat (5) @(posedge core_clk);
      #1;
      chk_bit(gate_drive_n, 1'b1, "gate in reset");
      @(posedge core_clk);
      reset <= 1'b0;
      wait_gate(1'b0, 20);
      chk_cnt(n, 9, 12, "measure time");
      chk_bit(measuring, 1'b0, "still measuring");
   endtask
   // ----
   // Scenarios
   // ----
   task automatic t_periodic();
      restart(1'b1, 8'h00);
      for (int i = 0; i < 2; i++) begin
         wait_gate(1'b1, 60);
         chk_cnt(n, IVL - GUARD, IVL - GUARD, "low width");
         wait_gate(1'b0, 20);
         chk_cnt(n, GUARD, GUARD, "guard width");
      end
      $display("test periodic done");
   endtask
   // Second ack in the same interval must change nothing
   task automatic t_ack();
      twice = 1'b1;
      restart(1'b1, 8'h0a);
      for (int i = 0; i < 2; i++) begin
         wait_gate(1'b1, 60);
         k = n;
         chk_cnt(k, 11, 18, "ack to gate off");
         wait_gate(1'b0, 60);
         chk_cnt(k + n, IVL, IVL, "period with ack");
      end
      twice = 1'b0;
      $display("test ack done");
   endtask
   task automatic t_oneshot();
      restart(1'b0, 8'h00);
      wait_gate(1'b1, 60);
      chk_cnt(n, IVL - GUARD, IVL - GUARD, "single pulse");
      wait_gate(1'b0, 80);
      chk_cnt(n, 80, 80, "idle after pulse");
      @(posedge core_clk);
      man <= 1'b1;
      repeat (2) @(posedge core_clk);
      man <= 1'b0;
      wait_gate(1'b0, 20);
      chk_cnt(n, 20, 20, "glitch ignored");
      ack_dly <= 8'h08;
      man <= 1'b1;
      wait_gate(1'b0, 15);
      chk_cnt(n, 5, 12, "manual to gate on");
      repeat (20) @(posedge core_clk);
      man <= 1'b0;
      #1;
      chk_bit(gate_drive_n, 1'b0, "ack while held");
      repeat (10) @(posedge core_clk);
      man <= 1'b1;
      repeat (8) @(posedge core_clk);
      man <= 1'b0;
      wait_gate(1'b1, 60);
      chk_cnt(n + 18, IVL - GUARD, IVL, "manual pulse");
      $display("test one-shot done");
   endtask
   task automatic tally_and_finish();
      $display("compared %0d, mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   initial begin
      reset = 1'b1;
      man = 1'b0;
      mode = 1'b1;
      twice = 1'b0;
      ack_dly = 8'h00;
      ivl_in.valid = 1'b1;
      ivl_in.cycles = 39'h28;
      err_total = 0;
      n_compared = 0;
      t_periodic();
      t_ack();
      t_oneshot();
      tally_and_finish();
   end
   // Run needs under 1000 cycles; 3000 means a hang
   initial begin
      repeat (3000) @(posedge core_clk);
      err_total++;
      tally_and_finish();
   end
endmodule
bind pgit_timer pgit_timer_props #(.GUARD_CYC(GUARD_CYC))
   pgit_timer_props_inst (.core_clk(core_clk), .reset(reset),
   .interval_set_manual_on(interval_set_manual_on),
   .interval_resistor(interval_resistor), .done(done),
   .mode_periodic(mode_periodic), .gate_drive_n(gate_drive_n),
   .measuring(measuring));
`default_nettype wire
